//--- spi_eeprom_fifo.sv
// Purpose: Dual-clock FIFO carrying page bytes from the serial side
// Assumes: DEPTH is a power of two, at least four
// Notes: Gray pointers crossed by two flops each way
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   input wire logic wr_clk_i,              // Filling side clock
   input wire logic wr_rst_n_i,            // Filling side reset, active low
   input wire logic wr_valid_i,            // Word offered
   input wire logic [WIDTH-1:0] wr_data_i, // Word to store
   output logic wr_ready_o,                // Room for a word
   input wire logic rd_clk_i,              // Draining side clock
   input wire logic rd_rst_n_i,            // Draining side reset, active low
   output logic rd_valid_o,                // Word available
   output logic [WIDTH-1:0] rd_data_o,     // Oldest word
   input wire logic rd_ready_i             // Word taken
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] wr_bin, wr_gray, next_wr_bin;
   logic [AW:0] rd_bin, rd_gray, next_rd_bin;
   logic [AW:0] rd_gray_meta, rd_gray_sync, wr_gray_meta, wr_gray_sync;

   // Full and empty from gray compare
   assign wr_ready_o = (wr_gray != {~rd_gray_sync[AW:AW-1], rd_gray_sync[AW-2:0]});
   assign rd_valid_o = (rd_gray != wr_gray_sync);
   assign rd_data_o = store[rd_bin[AW-1:0]];
   assign next_wr_bin = wr_bin + (AW+1)'(wr_valid_i && wr_ready_o);
   assign next_rd_bin = rd_bin + (AW+1)'(rd_valid_o && rd_ready_i);

   // Storage write
   always_ff @(posedge wr_clk_i) begin
      if (wr_valid_i && wr_ready_o) begin
         store[wr_bin[AW-1:0]] <= wr_data_i;
      end
   end

   // Write pointer
   always_ff @(posedge wr_clk_i or negedge wr_rst_n_i) begin
      if (!wr_rst_n_i) begin
         wr_bin <= '0;
         wr_gray <= '0;
      end else begin
         wr_bin <= next_wr_bin;
         wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
      end
   end

   // Read pointer seen on the write side
   always_ff @(posedge wr_clk_i or negedge wr_rst_n_i) begin
      if (!wr_rst_n_i) begin
         rd_gray_meta <= '0;
         rd_gray_sync <= '0;
      end else begin
         rd_gray_meta <= rd_gray;
         rd_gray_sync <= rd_gray_meta;
      end
   end

   // Read pointer
   always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
      if (!rd_rst_n_i) begin
         rd_bin <= '0;
         rd_gray <= '0;
      end else begin
         rd_bin <= next_rd_bin;
         rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
      end
   end

   // Write pointer seen on the read side
   always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
      if (!rd_rst_n_i) begin
         wr_gray_meta <= '0;
         wr_gray_sync <= '0;
      end else begin
         wr_gray_meta <= wr_gray;
         wr_gray_sync <= wr_gray_meta;
      end
   end
endmodule
`default_nettype wire

//--- spi_eeprom_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM front end
// Assumes: 40 MHz system clock, serial clock supplied by the host
// Notes: Opcodes compare after masking the don't-care bit
package spi_eeprom_pkg;

   // Data path sizes
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned MEM_DEPTH = 256;
   localparam int unsigned PAGE_BYTES = 16;
   localparam int unsigned ENTRY_W = ADDR_W + DATA_W;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Instruction decode
   localparam logic [7:0] OP_MASK = 8'hf7;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_CLR_WE = 8'h04;
   localparam logic [7:0] OP_SET_WE = 8'h06;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

   // Status byte layout
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_WEL_BIT = 1;
   localparam int unsigned ST_BP_LO = 2;
   localparam int unsigned ST_BP_HI = 3;
   localparam logic [3:0] ST_PAD = 4'h0;
   localparam logic [7:0] READ_BUSY_FILL = 8'hff;

   // Block protection levels and region bases
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [7:0] PROT_QUARTER_BASE = 8'hc0;
   localparam logic [7:0] PROT_HALF_BASE = 8'h80;

   // Internal write cycle time
   localparam int unsigned TWC_MS = 5;
   localparam int unsigned SYS_CLK_KHZ = 40000;
   localparam int unsigned TWC_CYCLES = TWC_MS * SYS_CLK_KHZ;
   localparam int unsigned CS_SYNC_CYCLES = 4;
   localparam int unsigned TIMER_W = $clog2(TWC_CYCLES + 1);

   // Serial frame phases
   typedef enum logic [2:0] {
      PH_OPCODE, PH_ADDR, PH_WRITE_DATA, PH_READ_DATA, PH_STATUS_OUT, PH_STATUS_IN, PH_IGNORE
   } phase_t;

   // Outcome of a serial frame
   typedef enum logic [2:0] {
      FK_NONE, FK_SET_WE, FK_CLR_WE, FK_WRITE, FK_STATUS_WRITE
   } frame_kind_t;

   // Internal write engine
   typedef enum logic [1:0] {E_IDLE, E_DRAIN, E_WAIT} engine_t;

endpackage

//--- spi_eeprom_props.sv
// Purpose: Port checks for the serial EEPROM front end
// Assumes: Write time shortened through WRITE_CYCLES
// Notes: Serial helpers clear while select is high
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_props
   import spi_eeprom_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = 64
) (
   input wire logic sys_clk_i,   // System clock
   input wire logic arst_n_i,    // Reset, active low
   input wire logic sck_i,       // Serial clock
   input wire logic cs_n_i,      // Select, active low
   input wire logic si_i,        // Serial in
   input wire logic hold_n_i,    // Pause, active low
   input wire logic so_o,        // Serial out
   input wire logic so_oe_o,     // Out enable
   input wire logic write_busy_o // Write busy
);
   logic [4:0] rises;
   logic [7:0] op;
   int busy_len;
   // Rises since select fell, and the opcode seen
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rises <= 5'h0;
         op <= 8'h0;
      end else if (hold_n_i && rises != 5'h1f) begin
         rises <= rises + 5'h1;
         if (rises < 5'h8) op <= {op[6:0], si_i};
      end
   end
   // Length of the running write
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) busy_len <= 0;
      else busy_len <= write_busy_o ? busy_len + 1 : 0;
   end
   property p_cs_float;
      @(posedge sys_clk_i) disable iff (!arst_n_i) cs_n_i && $past(cs_n_i) |-> !so_oe_o;
   endproperty
   a_cs_float: assert property (p_cs_float) else $error("out driven unselected");
   property p_hold_float;
      @(posedge sys_clk_i) disable iff (!arst_n_i) !hold_n_i && !$past(hold_n_i) |-> !so_oe_o;
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("out driven paused");
   property p_busy_start;
      @(posedge sys_clk_i) disable iff (!arst_n_i) $rose(write_busy_o) |-> cs_n_i && $past(cs_n_i, 2);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy without select rise");
   property p_busy_max;
      @(posedge sys_clk_i) disable iff (!arst_n_i) busy_len <= WRITE_CYCLES;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("write too long");
   property p_busy_min;
      @(posedge sys_clk_i) disable iff (!arst_n_i) $rose(write_busy_o) |-> write_busy_o[*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("write too short");
   property p_oe_cause;
      @(posedge sys_clk_i) disable iff (!arst_n_i) $rose(so_oe_o) |-> !cs_n_i && hold_n_i;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("out enabled wrongly");
   property p_op_quiet;
      @(posedge sck_i) disable iff (!arst_n_i || cs_n_i) rises < 5'h8 |-> !so_oe_o;
   endproperty
   a_op_quiet: assert property (p_op_quiet) else $error("out during opcode");
   property p_status_on;
      @(posedge sck_i) disable iff (!arst_n_i || cs_n_i)
         rises == 5'hf && hold_n_i && (op & OP_MASK) == OP_STATUS_READ |-> so_oe_o;
   endproperty
   a_status_on: assert property (p_status_on) else $error("status not driven");
endmodule
bind spi_eeprom_serial_front_end spi_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
   .sys_clk_i, .arst_n_i, .sck_i, .cs_n_i, .si_i, .hold_n_i, .so_o, .so_oe_o, .write_busy_o);
`default_nettype wire

//--- spi_eeprom_serial_front_end.sv
// Purpose: Serial front end of a 256-byte serial EEPROM
// Assumes: Host keeps the serial clock still while chip select is high
// Notes: Serial logic on sck_i, write engine and array on sys_clk_i
//
// Function
// - Opcode is shifted into an 8-bit instruction register before address or data.
// - Input bits are sampled on rising serial clock edges; host sets them up.
// - Opcode, address and data move most significant bit first, both directions.
// - First bit is taken on the first rising edge after select falls.
// - Pause freezes the frame and ignores clock and data; release resumes it. Output drive returns only at the next falling edge after release.
// - Select rising after a valid write starts a timed write under five ms.
// - Write time runs from that select rise to completion of the write.
// - Array holds 256 bytes reachable over the serial link.
// - Opcodes decode with bit 3 ignored into the six documented commands.
// - Busy status bit is one during a write, zero otherwise, read-only.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_serial_front_end
   import spi_eeprom_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = TWC_CYCLES
) (
   input wire logic sys_clk_i,   // System clock, 40 MHz
   input wire logic arst_n_i,    // Asynchronous reset, active low
   input wire logic sck_i,       // Serial clock from host
   input wire logic cs_n_i,      // Chip select, active low
   input wire logic si_i,        // Serial data in
   input wire logic hold_n_i,    // Pause input, active low
   output logic so_o,            // Serial data out
   output logic so_oe_o,         // Drive enable for serial data out
   output logic write_busy_o     // Internal write in progress
);
   localparam int unsigned RES_W = 2 + 3 + DATA_W;
   localparam logic [TIMER_W-1:0] TIMER_LAST =
      TIMER_W'(WRITE_CYCLES - CS_SYNC_CYCLES - 1);

   // Reset synchroniser
   logic [1:0] rst_pipe;
   logic rst_n;

   // Serial side state
   logic frame_rst_n, out_rst_n;
   phase_t phase;
   logic [2:0] bit_cnt;
   logic [6:0] rx_shift;
   logic [7:0] rx_byte, op_masked;
   logic op_is_write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] tx_byte;
   logic byte_done;
   logic overflow;
   logic [7:0] status_meta, status_sync;
   logic cmd_done;
   frame_kind_t next_kind;
   logic result_ok, result_ev;
   frame_kind_t result_kind;
   logic [DATA_W-1:0] result_data;
   logic fifo_wr_valid, fifo_wr_ready;

   // System side state
   logic cs_meta, cs_s2, cs_s3, cs_level, cs_rise;
   logic [RES_W-1:0] res_meta, res_sync;
   logic res_ev, res_ok, ev_seen;
   frame_kind_t res_kind;
   logic [DATA_W-1:0] res_data;
   engine_t state;
   logic busy, wel, commit;
   logic [1:0] bp;
   logic [TIMER_W-1:0] timer;
   logic [7:0] status_byte;
   logic new_result, do_set_we, do_clr_we, do_status_wr, do_write, cycle_done;
   logic fifo_rd_valid, fifo_rd_ready;
   logic [ENTRY_W-1:0] fifo_rd_data;
   logic [ADDR_W-1:0] wr_addr;
   logic mem_we;

   // Byte array, written by the engine, read by the serial side
   logic [DATA_W-1:0] mem [MEM_DEPTH];

   // Write protection by block
   function automatic logic is_protected(input logic [1:0] bp_v, input logic [7:0] a);
      case (bp_v)
         BP_NONE: is_protected = 1'b0;
         BP_QUARTER: is_protected = (a >= PROT_QUARTER_BASE);
         BP_HALF: is_protected = (a >= PROT_HALF_BASE);
         default: is_protected = 1'b1;
      endcase
   endfunction

   // Array byte for reading, refused while a write runs
   function automatic logic [7:0] read_byte(input logic busy_v, input logic [7:0] v);
      read_byte = busy_v ? READ_BUSY_FILL : v;
   endfunction

   // Reset release through two flops
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // ---------------- Serial clock domain ----------------

   // Frame state clears whenever select is high
   assign frame_rst_n = rst_n & ~cs_n_i;
   assign out_rst_n = frame_rst_n & hold_n_i;
   assign rx_byte = {rx_shift, si_i};
   assign op_masked = rx_byte & OP_MASK;
   assign byte_done = hold_n_i && (bit_cnt == BIT_LAST);
   assign fifo_wr_valid = (phase == PH_WRITE_DATA) && byte_done && !overflow;

   // Bit counter and input shift register
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt <= 3'h0;
         rx_shift <= 7'h00;
      end else if (hold_n_i) begin
         bit_cnt <= bit_cnt + 3'h1;
         rx_shift <= rx_byte[6:0];
      end
   end

   // Phase sequencing after each whole byte
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         phase <= PH_OPCODE;
         op_is_write <= 1'b0;
      end else if (byte_done) begin
         case (phase)
            PH_OPCODE: begin
               op_is_write <= (op_masked == OP_WRITE);
               if (op_masked == OP_READ || op_masked == OP_WRITE) begin
                  phase <= PH_ADDR;
               end else if (op_masked == OP_STATUS_READ) begin
                  phase <= PH_STATUS_OUT;
               end else if (op_masked == OP_STATUS_WRITE) begin
                  phase <= PH_STATUS_IN;
               end else begin
                  phase <= PH_IGNORE;
               end
            end
            PH_ADDR: begin
               phase <= op_is_write ? PH_WRITE_DATA : PH_READ_DATA;
            end
            PH_STATUS_IN: begin
               phase <= PH_IGNORE;
            end
            default: begin
            end
         endcase
      end
   end

   // Address pointer, sequential for reads, page wrap for writes
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         addr <= '0;
      end else if (byte_done) begin
         case (phase)
            PH_ADDR: addr <= rx_byte;
            PH_READ_DATA: addr <= addr + 8'h01;
            PH_WRITE_DATA: begin
               if (fifo_wr_ready) begin
                  addr <= {addr[7:4], addr[3:0] + 4'h1};
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Too many page bytes for the buffer spoils the write
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         overflow <= 1'b0;
      end else if (phase == PH_WRITE_DATA && byte_done && !fifo_wr_ready) begin
         overflow <= 1'b1;
      end
   end

   // Outgoing byte, loaded at the byte boundaries of read and status read frames only
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_byte <= '0;
      end else if (byte_done) begin
         if (phase == PH_ADDR && !op_is_write) begin
            tx_byte <= read_byte(status_sync[ST_BUSY_BIT], mem[rx_byte]);
         end else if (phase == PH_READ_DATA) begin
            tx_byte <= read_byte(status_sync[ST_BUSY_BIT], mem[addr + 8'h01]);
         end else if ((phase == PH_OPCODE && op_masked == OP_STATUS_READ) ||
                      phase == PH_STATUS_OUT) begin
            tx_byte <= status_sync;
         end
      end
   end

   // Status byte brought onto the serial clock
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         status_meta <= '0;
         status_sync <= '0;
      end else begin
         status_meta <= status_byte;
         status_sync <= status_meta;
      end
   end

   // Serial output after falling edges
   always_ff @(negedge sck_i or negedge out_rst_n) begin
      if (!out_rst_n) begin
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
      end else begin
         so_oe_o <= (phase == PH_READ_DATA) || (phase == PH_STATUS_OUT);
         so_o <= tx_byte[BIT_LAST - bit_cnt];
      end
   end

   // Which byte ends a command that may take effect
   always_comb begin
      cmd_done = 1'b0;
      next_kind = FK_NONE;
      if (byte_done) begin
         case (phase)
            PH_OPCODE: begin
               if (op_masked == OP_SET_WE) begin
                  cmd_done = 1'b1;
                  next_kind = FK_SET_WE;
               end else if (op_masked == OP_CLR_WE) begin
                  cmd_done = 1'b1;
                  next_kind = FK_CLR_WE;
               end
            end
            PH_STATUS_IN: begin
               cmd_done = 1'b1;
               next_kind = FK_STATUS_WRITE;
            end
            PH_WRITE_DATA: begin
               cmd_done = fifo_wr_ready && !overflow;
               next_kind = FK_WRITE;
            end
            default: begin
            end
         endcase
      end
   end

   // Frame outcome, valid only if select rises on a byte boundary
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         result_ok <= 1'b0;
         result_kind <= FK_NONE;
         result_data <= '0;
         result_ev <= 1'b0;
      end else if (hold_n_i && !cs_n_i) begin
         result_ok <= cmd_done;
         if (cmd_done) begin
            result_kind <= next_kind;
            result_data <= rx_byte;
            result_ev <= ~result_ev;
         end
      end
   end

   // Page bytes cross to the system clock
   spi_eeprom_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(PAGE_BYTES)
   ) u_page_fifo (
      .wr_clk_i(sck_i),
      .wr_rst_n_i(rst_n),
      .wr_valid_i(fifo_wr_valid),
      .wr_data_i({addr, rx_byte}),
      .wr_ready_o(fifo_wr_ready),
      .rd_clk_i(sys_clk_i),
      .rd_rst_n_i(rst_n),
      .rd_valid_o(fifo_rd_valid),
      .rd_data_o(fifo_rd_data),
      .rd_ready_i(fifo_rd_ready)
   );

   // ---------------- System clock domain ----------------

   // Select synchroniser, change counts when stages two and three agree
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cs_meta <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         cs_level <= 1'b1;
      end else begin
         cs_meta <= cs_n_i;
         cs_s2 <= cs_meta;
         cs_s3 <= cs_s2;
         if (cs_s2 == cs_s3) begin
            cs_level <= cs_s3;
         end
      end
   end
   assign cs_rise = (cs_s2 == cs_s3) && cs_s3 && !cs_level;

   // Frame outcome, stable while the serial clock is still
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         res_meta <= '0;
         res_sync <= '0;
      end else begin
         res_meta <= {result_ev, result_ok, result_kind, result_data};
         res_sync <= res_meta;
      end
   end
   assign res_ev = res_sync[RES_W-1];
   assign res_ok = res_sync[RES_W-2];
   assign res_kind = frame_kind_t'(res_sync[DATA_W +: 3]);
   assign res_data = res_sync[DATA_W-1:0];

   // Commands that take effect at select rise
   assign new_result = cs_rise && res_ok && (res_ev != ev_seen) && (state == E_IDLE);
   assign do_set_we = new_result && (res_kind == FK_SET_WE);
   assign do_clr_we = new_result && (res_kind == FK_CLR_WE);
   assign do_status_wr = new_result && (res_kind == FK_STATUS_WRITE) && wel;
   assign do_write = new_result && (res_kind == FK_WRITE);
   assign cycle_done = (state == E_WAIT) && (timer >= TIMER_LAST);

   // Each frame outcome is used once
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ev_seen <= 1'b0;
      end else if (cs_rise) begin
         ev_seen <= res_ev;
      end
   end

   // Write engine sequencing
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= E_IDLE;
         commit <= 1'b0;
      end else begin
         case (state)
            E_IDLE: begin
               if (do_write) begin
                  state <= E_DRAIN;
                  commit <= wel;
               end else if (do_status_wr) begin
                  state <= E_WAIT;
               end
            end
            E_DRAIN: begin
               if (!fifo_rd_valid) begin
                  state <= commit ? E_WAIT : E_IDLE;
               end
            end
            E_WAIT: begin
               if (cycle_done) begin
                  state <= E_IDLE;
               end
            end
            default: begin
               state <= E_IDLE;
            end
         endcase
      end
   end

   // Busy flag from select rise until the timed cycle ends
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else if (do_status_wr || (do_write && wel)) begin
         busy <= 1'b1;
      end else if (cycle_done) begin
         busy <= 1'b0;
      end
   end

   // Cycle timer, bounded below the maximum write time
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         timer <= '0;
      end else if (!busy) begin
         timer <= '0;
      end else begin
         timer <= timer + TIMER_W'(1);
      end
   end

   // Write enable latch and protection bits
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wel <= 1'b0;
         bp <= BP_NONE;
      end else begin
         if (do_set_we) begin
            wel <= 1'b1;
         end else if (do_clr_we || do_status_wr || cycle_done) begin
            wel <= 1'b0;
         end
         if (do_status_wr) begin
            bp <= res_data[ST_BP_HI:ST_BP_LO];
         end
      end
   end

   // Status as seen by the host
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         status_byte <= '0;
         write_busy_o <= 1'b0;
      end else begin
         status_byte <= {ST_PAD, bp, wel, busy};
         write_busy_o <= busy;
      end
   end

   // Drain committed page bytes; stray bytes are dropped
   assign fifo_rd_ready = (state == E_DRAIN) || (state == E_IDLE && cs_level);
   assign wr_addr = fifo_rd_data[ENTRY_W-1:DATA_W];
   assign mem_we = (state == E_DRAIN) && fifo_rd_valid && commit && !is_protected(bp, wr_addr);

   // Array write port
   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         mem[wr_addr] <= fifo_rd_data[DATA_W-1:0];
      end
   end
endmodule
`default_nettype wire

//--- spi_host_model.sv
// Purpose: Serial host driving the EEPROM front end
// Assumes: 12 ns serial clock, running only inside frames
// Notes: pause_bit picks a bit to pause before
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic sck_o,     // Serial clock
   output logic cs_n_o,    // Select, active low
   output logic si_o,      // Data to device
   output logic hold_n_o,  // Pause, active low
   input wire logic so_i,  // Data from device
   input wire logic so_oe_i // Device drives so_i
);
   int pause_bit = -1;
   int nbit;
   // Idle bus at time zero
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end
   // Select, then first rise after setup
   task automatic start();
      nbit = 0;
      cs_n_o = 1'b0;
      #10;
   endtask
   // Shift n bits, sampling the device on each rise
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      for (int i = 7; i > 7 - n; i--) begin
         si_o = tx[i];
         if (nbit == pause_bit) begin
            hold_n_o = 1'b0;
            repeat (3) begin
               si_o = ~si_o;
               #6 sck_o = 1'b1;
               #6 sck_o = 1'b0;
            end
            si_o = tx[i];
            hold_n_o = 1'b1;
         end
         #6 sck_o = 1'b1;
         rx = {rx[6:0], so_oe_i ? so_i : 1'bx};
         #6 sck_o = 1'b0;
         nbit++;
      end
   endtask
   // Deselect; data line no longer meaningful
   task automatic stop();
      #6 cs_n_o = 1'b1;
      si_o = ~si_o;
   endtask
endmodule
`default_nettype wire

//--- test_spi_eeprom_serial_front_end.sv
// Purpose: Self-checking bench for the serial EEPROM front end
// Assumes: WRITE_CYCLES of 64 keeps writes short
// Notes: Row table for writes, hand tests after
`timescale 1ns/1ps
`default_nettype none
module test_spi_eeprom_serial_front_end
   import spi_eeprom_pkg::*;
;
   typedef struct {logic [7:0] we; logic [7:0] op; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   row_t rows [4] = '{'{8'h06, 8'h02, 8'h00, 8'ha5, 8'ha5}, '{8'h0e, 8'h0a, 8'hff, 8'h3c, 8'h3c},
      '{8'h04, 8'h02, 8'h00, 8'h11, 8'ha5}, '{8'h06, 8'h0a, 8'hc0, 8'h5a, 8'h5a}};
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic sck, cs_n, si, hold_n, so, so_oe, busy;
   logic [7:0] got;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   spi_eeprom_serial_front_end #(.WRITE_CYCLES(64)) dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
      .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe),
      .write_busy_o(busy));
   spi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so),
      .so_oe_i(so_oe));
   always #12.5 sys_clk = ~sys_clk;
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One frame of nbits, last byte returned
   task automatic frame(input logic [31:0] tx, input int nbits, output logic [7:0] rx);
      @(posedge sys_clk);
      #2;
      host.start();
      for (int k = 0; k < nbits; k += 8)
         host.xfer(tx[31-k -: 8], (nbits - k > 8) ? 8 : nbits - k, rx);
      host.stop();
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
      if (busy !== 1'b0) n_fail++; // Write never ended
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      #2 arst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      check({7'h0, busy}, 8'h00);
      foreach (rows[i]) begin
         frame({rows[i].we, 24'h0}, 8, got);
         frame({rows[i].op, rows[i].a, rows[i].d, 8'h0}, 24, got);
         frame({OP_STATUS_READ, 24'h0}, 16, got);
         check({7'h0, got[0]}, {7'h0, rows[i].e == rows[i].d});
         wait_idle();
         frame({OP_STATUS_READ, 24'h0}, 16, got);
         check(got, 8'h00);
         frame({rows[i].op | 8'h01, rows[i].a, 16'h0}, 24, got);
         check(got, rows[i].e);
      end
      frame({OP_READ, 8'hff, 16'h0}, 32, got);
      check(got, 8'ha5);
      host.pause_bit = 12;
      frame({OP_READ, 8'hc0, 16'h0}, 24, got);
      check(got, 8'h5a);
      host.pause_bit = -1;
      frame({OP_SET_WE, 24'h0}, 8, got);
      frame({OP_WRITE, 8'h7f, 8'h81, 8'h0}, 24, got);
      frame({OP_READ, 8'h7f, 16'h0}, 24, got);
      check(got, READ_BUSY_FILL);
      wait_idle();
      frame({OP_SET_WE, 24'h0}, 8, got);
      frame({OP_WRITE, 8'h7f, 16'h0}, 20, got);
      check({7'h0, busy}, 8'h00);
      frame({OP_READ, 8'h7f, 16'h0}, 24, got);
      check(got, 8'h81);
      frame({OP_SET_WE, 24'h0}, 8, got);
      frame({OP_STATUS_WRITE, 8'h04, 16'h0}, 16, got);
      wait_idle();
      frame({OP_STATUS_READ, 24'h0}, 16, got);
      check(got, 8'h04);
      frame({OP_SET_WE, 24'h0}, 8, got);
      frame({OP_WRITE, 8'hc0, 8'h99, 8'h0}, 24, got);
      wait_idle();
      frame({OP_READ, 8'hc0, 16'h0}, 24, got);
      check(got, 8'h5a);
      // Reset in the middle of a write clears busy, latch and protection
      frame({OP_SET_WE, 24'h0}, 8, got);
      frame({OP_WRITE, 8'h10, 8'h77, 8'h0}, 24, got);
      #2 arst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      check({6'h0, so_oe, busy}, 8'h00);
      #2 arst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      frame({OP_STATUS_READ, 24'h0}, 16, got);
      check(got, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
